// File: power_swing_sequencer_test.sv
// Purpose: self-checking bench for the power swing sequencer
// Assumes: outputs settle within four cycles for zero delays
// Notes:   steady-state checks; timer bounds allow one tick of phase
`timescale 1ns/100ps
`default_nettype none

module power_swing_sequencer_test;
  import pss_pkg::*;
  localparam logic H = 1'h1;
  localparam logic L = 1'h0;
  logic          sys_clk_i = 1'h0;
  logic          srst      = 1'h1;
  logic          enable    = 1'h1;
  pss_mode_type  mode      = PSS_STEP_TWO;
  pss_trip_type  tmode     = PSS_TRIP_EARLY;
  pss_delay_type dly       = '0;
  pss_zone_type  zone;
  logic          inhib     = 1'h0;
  logic [1:0]    pos       = 2'h0;
  logic          jit       = 1'h0;
  logic          jit_en    = 1'h0;
  logic          sb, tr, raw;
  pss_seq_type   sq;
  logic [2:0]    raw_cnt   = 3'h0;
  logic [7:0]    exp_q[$];
  int            seed      = 32'h4ffc6e59;
  int            rnd;
  int            fail_count = 0;
  int            n_tests    = 0;

  always #50 sys_clk_i = ~sys_clk_i;

  pss_zone_model u_zone (.pos_i(pos), .jitter_i(jit), .zone_o(zone));
  pss_sequencer u_dut (.sys_clk_i(sys_clk_i), .srst_i(srst), .enable_i(enable),
    .mode_i(mode), .trip_mode_i(tmode), .zone_i(zone), .delay_i(dly),
    .trip_inhibit_in_i(inhib), .swing_block_o(sb), .trip_o(tr), .trip_raw_o(raw),
    .seq_state_o(sq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] expv);
    n_tests++;
    if (seen !== expv)
    begin
      $display("[FAIL] %s expected %h seen %h", name, expv, seen);
      fail_count++;
    end
  endtask : check

  task automatic chk(input logic b, input logic t, input pss_seq_type s, input logic [2:0] c);
    exp_q.push_back({b, t, s, c});
  endtask : chk

  task automatic go(input logic [1:0] p, input int n);
    pos <= p;
    repeat (n) @(posedge sys_clk_i);
  endtask : go

  task automatic print_verdict;
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  // middle flag noise only injected while two-step mode ignores it
  always @(posedge sys_clk_i)
  begin
    rnd = $random(seed);
    jit <= jit_en & rnd[0];
    if (raw === 1'h1)
      raw_cnt <= raw_cnt + 3'h1;
  end

  always @(negedge sys_clk_i)
    if (exp_q.size() != 0)
      check("outputs", {sb, tr, sq, raw_cnt}, exp_q.pop_front());

  initial
  begin
    repeat (32'h0001_86a0) @(posedge sys_clk_i);
    fail_count++;
    print_verdict();
  end

  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    srst <= 1'h0;
    dly.trip_hold_delay <= 16'h0002;
    jit_en <= 1'h1;
    @(posedge sys_clk_i);
    chk(L, L, PSS_SEQ_IDLE, 3'h0);
    go(2'h1, 4); chk(H, L, PSS_SEQ_STEP1, 3'h0);
    go(2'h3, 4); chk(H, H, PSS_SEQ_ARMED, 3'h1);
    go(2'h0, 4); chk(L, H, PSS_SEQ_IDLE, 3'h1);
    go(2'h0, 9000); chk(L, H, PSS_SEQ_IDLE, 3'h1);
    go(2'h0, 22000); chk(L, L, PSS_SEQ_IDLE, 3'h1);
    mode <= PSS_STEP_THREE;
    tmode <= PSS_TRIP_DELAYED;
    jit_en <= 1'h0;
    go(2'h1, 4); chk(H, L, PSS_SEQ_STEP1, 3'h1);
    inhib <= 1'h1;
    go(2'h2, 4); chk(H, L, PSS_SEQ_STEP2, 3'h1);
    go(2'h3, 4); chk(H, L, PSS_SEQ_ARMED, 3'h1);
    go(2'h1, 4); chk(H, L, PSS_SEQ_LATCH4, 3'h1);
    go(2'h0, 4); chk(L, L, PSS_SEQ_IDLE, 3'h2);
    enable <= 1'h0;
    inhib <= 1'h0;
    go(2'h1, 4); chk(L, L, PSS_SEQ_IDLE, 3'h2);
    srst <= 1'h1;
    repeat (2) @(posedge sys_clk_i);
    srst <= 1'h0;
    enable <= 1'h1;
    mode <= PSS_STEP_TWO;
    dly.pickup1 <= 16'h0002;
    dly.reset1 <= 16'h0002;
    go(2'h1, 10000); chk(L, L, PSS_SEQ_IDLE, 3'h2);
    go(2'h1, 10010); chk(H, L, PSS_SEQ_STEP1, 3'h2);
    go(2'h0, 10000); chk(H, L, PSS_SEQ_IDLE, 3'h2);
    go(2'h0, 10010); chk(L, L, PSS_SEQ_IDLE, 3'h2);
    @(posedge sys_clk_i);
    print_verdict();
  end
endmodule : power_swing_sequencer_test

`default_nettype wire

// File: pss_pkg.sv
// Purpose: shared constants and types for the power swing sequencer
// Assumes: 10 MHz sys_clk_i, delays set in whole milliseconds
// Notes:   timers count 1 ms ticks from a free prescaler
package pss_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned TICK_US         = 1000;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [13:0] TICK_LAST       = 14'(TICK_CYCLES - 1);
  localparam logic [13:0] PRESCALE_RESET  = 14'h0000;
  localparam logic [15:0] TIMER_RESET     = 16'h0000;
  localparam int unsigned DELAY_W         = 16;

  typedef enum logic [1:0]
  {
    PSS_STEP_TWO   = 2'b00,
    PSS_STEP_THREE = 2'b01
  } pss_mode_type;

  typedef enum logic
  {
    PSS_TRIP_EARLY   = 1'b0,
    PSS_TRIP_DELAYED = 1'b1
  } pss_trip_type;

  // impedance position flags from the boundary comparators
  typedef struct packed
  {
    logic in_outer;
    logic in_middle;
    logic in_inner;
  } pss_zone_type;

  // every delay in milliseconds, 0 to 65535
  typedef struct packed
  {
    logic [DELAY_W-1:0] pickup1;
    logic [DELAY_W-1:0] reset1;
    logic [DELAY_W-1:0] pickup2;
    logic [DELAY_W-1:0] pickup3;
    logic [DELAY_W-1:0] pickup4;
    logic [DELAY_W-1:0] trip_hold_delay;
  } pss_delay_type;

  typedef enum logic [2:0]
  {
    PSS_SEQ_IDLE   = 3'b000,
    PSS_SEQ_STEP1  = 3'b001,
    PSS_SEQ_STEP2  = 3'b010,
    PSS_SEQ_ARMED  = 3'b011,
    PSS_SEQ_LATCH4 = 3'b100
  } pss_seq_type;

endpackage : pss_pkg

// File: pss_sequencer.sv
// Purpose: swing-block and out-of-step trip sequencing with timers
// Assumes: zone flags and settings synchronous to sys_clk_i
// Notes:   all delays counted in 1 ms ticks of a shared prescaler
//
// Overview of operation
// - block latch after pickup1 in first zone
// - leaving outer starts reset1, then block clears
// - three-step: middle-to-inner for pickup2 completes step two
// - inside inner for pickup3 arms the element
// - delayed mode: outside inner for pickup4 arms trip
// - delayed mode: raw trip pulse on outer exit
// - early mode: trip pulse when final step completes
// - trip held for trip_hold_delay after raised
// - trip_inhibit_in forces trip low, sequence continues
// - inhibit never touches swing-block detection
// - middle flag ignored unless three-step mode
// - delays 0 to 65.535 s, 1 ms steps
// - outer exit clears out-of-step sequence progress
// - disable keeps both outputs low
`timescale 1ns/100ps
`default_nettype none

module pss_sequencer
  import pss_pkg::*;
(
  input  wire logic                   sys_clk_i,
  input  wire logic                   srst_i,
  input  wire logic                   enable_i,
  input  wire pss_pkg::pss_mode_type  mode_i,
  input  wire pss_pkg::pss_trip_type  trip_mode_i,
  input  wire pss_pkg::pss_zone_type  zone_i,
  input  wire pss_pkg::pss_delay_type delay_i,
  input  wire logic                   trip_inhibit_in_i,
  output logic                        swing_block_o,
  output logic                        trip_o,
  output logic                        trip_raw_o,
  output pss_pkg::pss_seq_type        seq_state_o
);

  import pss_pkg::*;

  // true once a timer has counted up to its limit
  function automatic logic timer_done(input logic [DELAY_W-1:0] cnt,
                                      input logic [DELAY_W-1:0] lim);
    timer_done = (cnt >= lim);
  endfunction : timer_done

  function automatic logic [DELAY_W-1:0] timer_step(input logic [DELAY_W-1:0] cnt,
                                                    input logic               run,
                                                    input logic               tick,
                                                    input logic [DELAY_W-1:0] lim);
    if (!run)
      timer_step = TIMER_RESET;
    else if (tick && (cnt < lim))
      timer_step = cnt + 16'h0001;
    else
      timer_step = cnt;
  endfunction : timer_step

  ////////////////////////////////////////////////////////////////////////////
  // 1 ms time base
  logic [13:0] prescale_q;
  logic [13:0] prescale_d;
  logic        tick;

  always_comb
  begin
    tick       = (prescale_q == TICK_LAST);
    prescale_d = tick ? PRESCALE_RESET : prescale_q + 14'h0001;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      prescale_q <= PRESCALE_RESET;
    else
      prescale_q <= prescale_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // zone decoding
  logic three_step;
  logic mid_eff;
  logic zone1;
  logic zone2;
  logic inner;
  logic outer;

  always_comb
  begin
    three_step = (mode_i == PSS_STEP_THREE);
    mid_eff    = three_step & zone_i.in_middle;
    outer      = enable_i & zone_i.in_outer;
    inner      = outer & zone_i.in_inner;
    // first zone: outer minus middle (three-step) or minus inner
    zone1      = outer & (three_step ? ~mid_eff : ~zone_i.in_inner);
    zone2      = outer & mid_eff & ~zone_i.in_inner;
  end

  ////////////////////////////////////////////////////////////////////////////
  // swing-block latch with dropout timer
  logic               block_q;
  logic               block_d;
  logic [DELAY_W-1:0] pu1_q;
  logic [DELAY_W-1:0] pu1_d;
  logic [DELAY_W-1:0] rst1_q;
  logic [DELAY_W-1:0] rst1_d;

  always_comb
  begin
    pu1_d   = timer_step(pu1_q, zone1, tick, delay_i.pickup1);
    // reset timer runs only while latched and outside the outer boundary
    rst1_d  = timer_step(rst1_q, block_q & ~outer, tick, delay_i.reset1);
    block_d = block_q;
    if (!enable_i)
      block_d = 1'b0;
    else if (zone1 && timer_done(pu1_q, delay_i.pickup1))
      block_d = 1'b1;
    else if (block_q && !outer && timer_done(rst1_q, delay_i.reset1))
      block_d = 1'b0;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      block_q <= 1'b0;
      pu1_q   <= TIMER_RESET;
      rst1_q  <= TIMER_RESET;
    end
    else
    begin
      block_q <= block_d;
      pu1_q   <= pu1_d;
      rst1_q  <= rst1_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // out-of-step sequence
  pss_seq_type        seq_q;
  pss_seq_type        seq_d;
  logic [DELAY_W-1:0] stp_q;
  logic [DELAY_W-1:0] stp_d;
  logic               stp_run;
  logic [DELAY_W-1:0] stp_lim;
  logic               raw_d;
  logic               raw_q;

  // one shared step timer: only one step is timed at a time
  always_comb
  begin
    stp_run = 1'b0;
    stp_lim = delay_i.pickup1;
    case (seq_q)
      PSS_SEQ_IDLE:
      begin
        stp_run = zone1;
        stp_lim = delay_i.pickup1;
      end
      PSS_SEQ_STEP1:
      begin
        stp_run = three_step ? zone2 : inner;
        stp_lim = three_step ? delay_i.pickup2 : delay_i.pickup3;
      end
      PSS_SEQ_STEP2:
      begin
        stp_run = inner;
        stp_lim = delay_i.pickup3;
      end
      PSS_SEQ_ARMED:
      begin
        stp_run = outer & ~zone_i.in_inner;
        stp_lim = delay_i.pickup4;
      end
      default:
      begin
        stp_run = 1'b0;
        stp_lim = delay_i.pickup1;
      end
    endcase
  end

  always_comb
  begin
    stp_d = timer_step(stp_q, stp_run, tick, stp_lim);
    seq_d = seq_q;
    raw_d = 1'b0;
    if (!outer)
    begin
      // outer exit is the delayed trip moment, then progress is lost
      if ((seq_q == PSS_SEQ_LATCH4) && enable_i)
        raw_d = 1'b1;
      seq_d = PSS_SEQ_IDLE;
      stp_d = TIMER_RESET;
    end
    else if (stp_run && timer_done(stp_q, stp_lim))
    begin
      stp_d = TIMER_RESET;
      case (seq_q)
        PSS_SEQ_IDLE:
          seq_d = PSS_SEQ_STEP1;
        PSS_SEQ_STEP1:
        begin
          if (three_step)
            seq_d = PSS_SEQ_STEP2;
          else
          begin
            seq_d = PSS_SEQ_ARMED;
            raw_d = (trip_mode_i == PSS_TRIP_EARLY);
          end
        end
        PSS_SEQ_STEP2:
        begin
          seq_d = PSS_SEQ_ARMED;
          raw_d = (trip_mode_i == PSS_TRIP_EARLY);
        end
        PSS_SEQ_ARMED:
          if (trip_mode_i == PSS_TRIP_DELAYED)
            seq_d = PSS_SEQ_LATCH4;
        default:
          seq_d = PSS_SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      seq_q <= PSS_SEQ_IDLE;
      stp_q <= TIMER_RESET;
      raw_q <= 1'b0;
    end
    else
    begin
      seq_q <= seq_d;
      stp_q <= stp_d;
      raw_q <= raw_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trip seal-in; inhibit masks the output only, never the sequence
  logic               seal_q;
  logic               seal_d;
  logic [DELAY_W-1:0] hold_q;
  logic [DELAY_W-1:0] hold_d;
  logic               trip_q;
  logic               trip_d;

  always_comb
  begin
    seal_d = seal_q;
    hold_d = hold_q;
    if (!enable_i)
    begin
      seal_d = 1'b0;
      hold_d = TIMER_RESET;
    end
    else if (raw_q)
    begin
      seal_d = 1'b1;
      hold_d = TIMER_RESET;
    end
    else if (seal_q)
    begin
      hold_d = timer_step(hold_q, 1'b1, tick, delay_i.trip_hold_delay);
      if (timer_done(hold_q, delay_i.trip_hold_delay))
        seal_d = 1'b0;
    end
    trip_d = enable_i & (seal_d | raw_d) & ~trip_inhibit_in_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      seal_q <= 1'b0;
      hold_q <= TIMER_RESET;
      trip_q <= 1'b0;
    end
    else
    begin
      seal_q <= seal_d;
      hold_q <= hold_d;
      trip_q <= trip_d;
    end
  end

  // block output ignores trip_inhibit_in entirely
  assign swing_block_o = block_q;
  assign trip_o        = trip_q;
  assign trip_raw_o    = raw_q;
  assign seq_state_o   = seq_q;

endmodule : pss_sequencer

`default_nettype wire

// File: pss_sequencer_properties.sv
// Purpose: port-level checks for the power swing sequencer
// Assumes: single clock, synchronous active-high reset
// Notes:   bound to every pss_sequencer instance
`timescale 1ns/100ps
`default_nettype none

module pss_sequencer_chk
  import pss_pkg::*;
(
  input wire logic                   sys_clk_i,
  input wire logic                   srst_i,
  input wire logic                   enable_i,
  input wire pss_pkg::pss_mode_type  mode_i,
  input wire pss_pkg::pss_trip_type  trip_mode_i,
  input wire pss_pkg::pss_zone_type  zone_i,
  input wire pss_pkg::pss_delay_type delay_i,
  input wire logic                   trip_inhibit_in_i,
  input wire logic                   swing_block_o,
  input wire logic                   trip_o,
  input wire logic                   trip_raw_o,
  input wire pss_pkg::pss_seq_type   seq_state_o
);
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  ////////////////////////////////////////////////////////////////////////////
  AST_DIS: assert property (!enable_i |=> !swing_block_o && !trip_o)
    else $error("output active while disabled");
  // two cycles of inhibit so registered or gated outputs both qualify
  AST_INH: assert property (trip_inhibit_in_i && $past(trip_inhibit_in_i) |-> !trip_o)
    else $error("trip while inhibited");
  AST_RAW: assert property (trip_raw_o |=> !trip_raw_o)
    else $error("raw trip longer than one cycle");
  AST_SEAL: assert property (trip_raw_o && enable_i && !trip_inhibit_in_i
    && !$past(trip_inhibit_in_i) |-> trip_o)
    else $error("raw trip not sealed");
  AST_CLR: assert property (!zone_i.in_outer |=> seq_state_o == PSS_SEQ_IDLE)
    else $error("sequence kept after outer exit");
  AST_EARLY: assert property (enable_i && $past(trip_mode_i) == PSS_TRIP_EARLY
    && seq_state_o == PSS_SEQ_ARMED && $past(seq_state_o) != PSS_SEQ_ARMED
    |-> trip_raw_o)
    else $error("no early trip on arming");
  AST_DLY: assert property (trip_raw_o && $past(trip_mode_i) == PSS_TRIP_DELAYED
    |-> seq_state_o == PSS_SEQ_IDLE && !$past(zone_i.in_outer))
    else $error("delayed trip without outer exit");
  AST_SBSET: assert property ($rose(swing_block_o) |-> $past(enable_i && zone_i.in_outer
    && !zone_i.in_inner && (mode_i != PSS_STEP_THREE || !zone_i.in_middle)))
    else $error("swing block set outside first zone");
  AST_SBCLR: assert property ($fell(swing_block_o)
    |-> $past(!zone_i.in_outer || !enable_i))
    else $error("swing block cleared inside outer");
endmodule : pss_sequencer_chk

bind pss_sequencer pss_sequencer_chk u_chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
  .enable_i(enable_i), .mode_i(mode_i), .trip_mode_i(trip_mode_i), .zone_i(zone_i),
  .delay_i(delay_i), .trip_inhibit_in_i(trip_inhibit_in_i), .swing_block_o(swing_block_o),
  .trip_o(trip_o), .trip_raw_o(trip_raw_o), .seq_state_o(seq_state_o));

`default_nettype wire

// File: pss_zone_model.sv
// Purpose: boundary comparator stand-in driving the zone flags
// Assumes: nested boundaries, inner inside middle inside outer
// Notes:   jitter_i corrupts only the middle flag, for mode tests
`timescale 1ns/100ps
`default_nettype none

module pss_zone_model
  import pss_pkg::*;
(
  input  wire logic [1:0]        pos_i,
  input  wire logic              jitter_i,
  output pss_pkg::pss_zone_type  zone_o
);
  always_comb
  begin
    zone_o.in_outer  = pos_i != 2'h0;
    zone_o.in_middle = pos_i[1] | jitter_i;
    zone_o.in_inner  = pos_i == 2'h3;
  end
endmodule : pss_zone_model

`default_nettype wire
